//--- logic/vps_stage_logic.v
// Voltage protection stages: pickup, timing, reset and outputs
`timescale 1ns/1ps
`default_nettype none
`include "vps_defs.vh"
////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Log curve time is 5.8 minus 1.35 times ln(U/(k*Us)), or ln(Us/(k*U)) on undervoltage stages.
// - Coefficient k clamps to 0.30..1.00 in steps of 0.01.
// - Hold timer exists only on the first stage of each family.
// - Zero hold clears the timer once below 95 percent.
// - Nonzero hold keeps the timer; a returning fault resumes it.
// - Inverse reset ignores hold and uses the reset multiplier.
// - Reset type bit: 1 inverse, 0 definite.
// - Inverse reset time is multiplier*tr/(1-ratio^P).
// - tr per standard curve from table, P is 2.
// - tr zero for other curves; P zero for the log curve.
// - Definite operate time forces definite reset.
// - Three undervoltage stages, phase-neutral or phase-phase.
// - OR operates on any phase, AND only on all three.
// - Breaker-qualified modes also need the breaker closed.
// - Trip stages drive trip and pulse, alarm stages alarm.
// - First two undervoltage stages offer the same inverse curves.
// - First residual stage inverse or definite, others definite.
// - Residual from measured input or sum of phase voltages.
// - Two negative-sequence stages, first may be inverse.
// - Negative-sequence stage picks up above threshold.
////////////////////////////////////////////////////////////////////////
module vps_stage_logic #(
	parameter TICK_CYC = `VPS_TICK_NS / `VPS_CLK_PERIOD_NS
) (
	input wire clk_i, // System clock
	input wire resetn_i, // Async reset, active low
	input wire [6:0] addr_i, // Register word index
	input wire [15:0] wdata_i, // Write data
	input wire wr_i, // Write strobe
	input wire rd_i, // Read strobe
	output reg [15:0] rdata_o, // Read data, cycle after strobe
	input wire [15:0] van_i, // Phase A to neutral
	input wire [15:0] vbn_i, // Phase B to neutral
	input wire [15:0] vcn_i, // Phase C to neutral
	input wire [15:0] vab_i, // Phase A to B
	input wire [15:0] vbc_i, // Phase B to C
	input wire [15:0] vca_i, // Phase C to A
	input wire [15:0] res_i, // Measured residual voltage
	input wire [15:0] nseq_i, // Negative-sequence voltage
	input wire breaker_closed_contact_i, // Breaker closed, pin
	output reg prot_trip_o, // Protection trip level
	output reg trip_pulse_o, // One-cycle trip pulse
	output reg alarm_o // Alarm level
);

// Prescaler end point, cut to the counter width on purpose
localparam integer TICK_M1 = TICK_CYC - 1;
localparam [16:0] TICK_LAST = TICK_M1[16:0];
localparam [31:0] ONE = `VPS_ONE_Q12;
localparam [31:0] DROP = `VPS_ONE_Q12 * `VPS_DROP_PCT / `VPS_HUNDRED;
localparam [7:0] UNDER_M = `VPS_UNDER_MASK;
localparam [7:0] RES_M = `VPS_RES_MASK;
localparam [7:0] INV_M = `VPS_INV_MASK;
localparam [7:0] HOLD_M = `VPS_HOLD_MASK;

////////////////////////////////////////////////////////////////////////
// Functions

// Restoring divider, saturates on overflow or zero divisor
function [31:0] div_sat;
	input [47:0] n;
	input [31:0] d;
	reg [48:0] r;
	reg [47:0] q;
	integer i;
	begin
		r = 49'h0;
		q = 48'h0;
		for (i = 47; i >= 0; i = i - 1) begin
			r = {r[47:0], n[i]};
			if (r >= {17'h0, d}) begin
				r = r - {17'h0, d};
				q[i] = 1'b1;
			end
		end
		if (d == 32'h0 || q[47:32] != 16'h0)
			div_sat = 32'hffffffff;
		else
			div_sat = q[31:0];
	end
endfunction

// Log2 in Q8, linear between powers of two
function [15:0] lg2q;
	input [31:0] x;
	reg [4:0] p;
	reg [31:0] y;
	integer i;
	begin
		p = 5'h0;
		for (i = 0; i < 32; i = i + 1)
			if (x[i])
				p = i[4:0];
		y = x << (5'h1f - p);
		lg2q = {3'h0, p, y[30:23]};
	end
endfunction

// Larger of two voltages
function [15:0] vmax;
	input [15:0] a;
	input [15:0] b;
	begin
		vmax = (a > b) ? a : b;
	end
endfunction

// Reset constant per curve code
function [16:0] tr_ms;
	input [3:0] c;
	begin
		case (c)
		4'h0: tr_ms = `VPS_TR_IEC_SI;
		4'h1: tr_ms = `VPS_TR_IEC_VI;
		4'h2: tr_ms = `VPS_TR_IEC_EI;
		4'h6: tr_ms = `VPS_TR_IEEE_MI;
		4'h7: tr_ms = `VPS_TR_IEEE_VI;
		4'h8: tr_ms = `VPS_TR_IEEE_EI;
		4'h9: tr_ms = `VPS_TR_US_CO8;
		4'ha: tr_ms = `VPS_TR_US_STI;
		4'hb: tr_ms = `VPS_TR_US_STI;
		default: tr_ms = `VPS_TR_ZERO;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////
// Storage

reg [15:0] cfg_q [0:7];
reg [15:0] thr_q [0:7];
reg [15:0] tim_q [0:7];
reg [15:0] rst_q [0:7];
reg [15:0] k_q [0:7];
reg [19:0] acc_q [0:7];
reg [19:0] hc_q [0:7];
reg [7:0] op_q;
reg [7:0] opt_q;
reg [7:0] opa_q;
reg [7:0] pk_q;
reg [7:0] pend_q;
reg [7:0] pend_d;
reg [2:0] idx_q;
reg [16:0] pre_q;
reg tick_q;
reg bs1_q;
reg bs2_q;
reg bs3_q;
reg brk_q;
integer i;
integer j;

////////////////////////////////////////////////////////////////////////
// Breaker contact: three flops, accepted when last two agree

always @(posedge clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		bs1_q <= 1'b0;
		bs2_q <= 1'b0;
		bs3_q <= 1'b0;
		brk_q <= 1'b0;
	end else begin
		bs1_q <= breaker_closed_contact_i;
		bs2_q <= bs1_q;
		bs3_q <= bs2_q;
		if (bs2_q == bs3_q)
			brk_q <= bs3_q;
	end
end

////////////////////////////////////////////////////////////////////////
// Millisecond tick and stage scan

always @(posedge clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		pre_q <= 17'h0;
		tick_q <= 1'b0;
		idx_q <= 3'h0;
	end else begin
		idx_q <= idx_q + 3'h1;
		tick_q <= (pre_q == TICK_LAST);
		if (pre_q == TICK_LAST)
			pre_q <= 17'h0;
		else
			pre_q <= pre_q + 17'h1;
	end
end

// Pending ticks; a new tick wins over the visit that consumes one
always @* begin
	pend_d = pend_q;
	pend_d[idx_q] = 1'b0;
	if (tick_q)
		pend_d = 8'hff;
end

always @(posedge clk_i or negedge resetn_i) begin
	if (!resetn_i)
		pend_q <= 8'h00;
	else
		pend_q <= pend_d;
end

////////////////////////////////////////////////////////////////////////
// Current stage settings and measured quantity

wire [15:0] cfg_w = cfg_q[idx_q];
wire [15:0] thr_w = thr_q[idx_q];
wire [15:0] tim_w = tim_q[idx_q];
wire [15:0] rst_w = rst_q[idx_q];
wire [15:0] k_w = k_q[idx_q];
wire [19:0] acc_w = acc_q[idx_q];
wire [19:0] hc_w = hc_q[idx_q];
wire tk_w = pend_q[idx_q];
wire under_w = UNDER_M[idx_q];
wire resid_w = RES_M[idx_q];
wire [3:0] crv_w = cfg_w[`VPS_C_CRV_HI:`VPS_C_CRV_LO];

// Phase set per stage setting
wire pp_w = cfg_w[`VPS_C_PP];
wire [15:0] pa_w = pp_w ? vab_i : van_i;
wire [15:0] pb_w = pp_w ? vbc_i : vbn_i;
wire [15:0] pc_w = pp_w ? vca_i : vcn_i;
wire [15:0] hi_w = vmax(vmax(pa_w, pb_w), pc_w);
wire [15:0] lo_w = ~vmax(vmax(~pa_w, ~pb_w), ~pc_w);

// OR follows the lowest phase, AND the highest one
wire [15:0] uv_w = cfg_w[`VPS_C_AND] ? hi_w : lo_w;

// Calculated residual saturates rather than wraps
wire [17:0] sum_w = {2'h0, van_i} + {2'h0, vbn_i} + {2'h0, vcn_i};
wire [15:0] calc_w = (sum_w[17:16] != 2'h0) ? 16'hffff : sum_w[15:0];
wire [15:0] ef_w = cfg_w[`VPS_C_CALC] ? calc_w : res_i;

// Negative sequence in the remaining stages
wire [15:0] m_w = under_w ? uv_w : (resid_w ? ef_w : nseq_i);

// Excursion ratio, above one means faulty
wire [15:0] rn_w = under_w ? thr_w : m_w;
wire [15:0] rd_w = under_w ? m_w : thr_w;
wire [31:0] ratio_w = div_sat({20'h0, rn_w, 12'h0}, {16'h0, rd_w});
wire pick_w = (ratio_w > ONE);
wire drop_w = (ratio_w < DROP);

// Enable and breaker qualification
wire qual_w = cfg_w[`VPS_C_EN] & (~cfg_w[`VPS_C_BRK] | brk_q);
wire fault_w = qual_w & pick_w;

// Inverse only on the stages that offer it
wire inv_w = cfg_w[`VPS_C_INV] & INV_M[idx_q];
wire hold_w = HOLD_M[idx_q];
wire rinv_w = (cfg_w[`VPS_C_RINV] == `VPS_RST_INV);

////////////////////////////////////////////////////////////////////////
// Logarithmic curve operate time

wire [15:0] lr_w = lg2q(ratio_w);
wire [15:0] lk_w = lg2q({16'h0, k_w});
wire [15:0] l100_w = lg2q(`VPS_HUNDRED);
wire [15:0] l1_w = lg2q(ONE);
reg signed [63:0] lgd;
reg signed [63:0] lgt;
reg [31:0] logt;

// Q8 log difference times 1350 ms times ln2 gives the slope term
always @* begin
	lgd = $signed({48'h0, lr_w}) + $signed({48'h0, l100_w});
	lgd = lgd - $signed({48'h0, lk_w}) - $signed({48'h0, l1_w});
	lgt = `VPS_LOG_A_MS - ((`VPS_LOG_B_MS * `VPS_LN2_Q16 * lgd) >>> 24);
	if (lgt < 64'sh0)
		logt = 32'h0;
	else
		logt = lgt[31:0];
end

// Standard curves take their operate time from the time setting
wire [31:0] top_w = (inv_w && crv_w == `VPS_CRV_LOG) ?
	logt : {16'h0, tim_w};

////////////////////////////////////////////////////////////////////////
// Reset duration

wire [16:0] trv_w = tr_ms(crv_w);
wire [1:0] pexp_w = (crv_w == `VPS_CRV_LOG) ? `VPS_P_LOG : `VPS_P_STD;
wire [31:0] sq_w = ratio_w[15:0] * ratio_w[15:0];
wire [32:0] rtr_w = rst_w * trv_w;
reg [31:0] pw;
reg [31:0] dn;
reg [31:0] rt;

// Ratio raised to P; the term is zero unless below one
always @* begin
	if (pexp_w == 2'h0 || ratio_w >= ONE)
		pw = ONE;
	else
		pw = {12'h0, sq_w[31:12]};
	dn = ONE - pw;
	if (!inv_w)
		rt = hold_w ? {16'h0, rst_w} : 32'h0;
	else if (rinv_w) begin
		if (trv_w == 17'h0 || dn == 32'h0)
			rt = 32'h0;
		else
			rt = div_sat({3'h0, rtr_w, 12'h0}, dn * `VPS_HUNDRED);
	end else
		rt = hold_w ? {16'h0, rst_w} : 32'h0;
end

////////////////////////////////////////////////////////////////////////
// Stage timer update

reg [19:0] acc_d;
reg [19:0] hc_d;
reg op_d;

// Faults accumulate; drop-off runs the hold or reset timer
always @* begin
	acc_d = acc_w;
	hc_d = hc_w;
	if (fault_w) begin
		hc_d = 20'h0;
		if (tk_w && acc_w != 20'hfffff)
			acc_d = acc_w + 20'h1;
	end else if (!qual_w || (drop_w && rt == 32'h0)) begin
		acc_d = 20'h0;
		hc_d = 20'h0;
	end else if (drop_w && tk_w) begin
		if ({12'h0, hc_w} + 32'h1 >= rt) begin
			acc_d = 20'h0;
			hc_d = 20'h0;
		end else
			hc_d = hc_w + 20'h1;
	end
	op_d = fault_w && ({12'h0, acc_d} >= top_w);
end

// Timer arrays are written only by the scan
always @(posedge clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		for (i = 0; i < 8; i = i + 1) begin
			acc_q[i] <= 20'h0;
			hc_q[i] <= 20'h0;
		end
		op_q <= 8'h00;
		opt_q <= 8'h00;
		opa_q <= 8'h00;
		pk_q <= 8'h00;
	end else begin
		acc_q[idx_q] <= acc_d;
		hc_q[idx_q] <= hc_d;
		op_q[idx_q] <= op_d;
		pk_q[idx_q] <= fault_w;
		opt_q[idx_q] <= op_d & ~cfg_w[`VPS_C_ALM];
		opa_q[idx_q] <= op_d & cfg_w[`VPS_C_ALM];
	end
end

////////////////////////////////////////////////////////////////////////
// Outputs

// Pulse marks each rise of the combined trip
always @(posedge clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		prot_trip_o <= 1'b0;
		trip_pulse_o <= 1'b0;
		alarm_o <= 1'b0;
	end else begin
		prot_trip_o <= |opt_q;
		trip_pulse_o <= (|opt_q) & ~prot_trip_o;
		alarm_o <= |opa_q;
	end
end

////////////////////////////////////////////////////////////////////////
// Register writes

wire st_w = wr_i && !addr_i[6];
wire [2:0] ws_w = addr_i[5:3];
wire [2:0] wf_w = addr_i[2:0];

// Coefficient is clamped so an out-of-range value never reaches the log
always @(posedge clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		for (j = 0; j < 8; j = j + 1) begin
			cfg_q[j] <= `VPS_CFG_RST;
			thr_q[j] <= `VPS_THR_RST;
			tim_q[j] <= `VPS_TIM_RST;
			rst_q[j] <= `VPS_RST_RST;
			k_q[j] <= `VPS_K_RST;
		end
	end else if (st_w) begin
		case (wf_w)
		`VPS_F_CFG: cfg_q[ws_w] <= wdata_i;
		`VPS_F_THR: thr_q[ws_w] <= wdata_i;
		`VPS_F_TIM: tim_q[ws_w] <= wdata_i;
		`VPS_F_RST: rst_q[ws_w] <= wdata_i;
		`VPS_F_K: begin
			if (wdata_i < `VPS_K_MIN)
				k_q[ws_w] <= `VPS_K_MIN;
			else if (wdata_i > `VPS_K_MAX)
				k_q[ws_w] <= `VPS_K_MAX;
			else
				k_q[ws_w] <= wdata_i;
		end
		default: ;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// Register reads, data valid only in the cycle after the strobe

reg [15:0] rmux;

always @* begin
	rmux = 16'h0;
	if (!addr_i[6]) begin
		case (wf_w)
		`VPS_F_CFG: rmux = cfg_q[ws_w];
		`VPS_F_THR: rmux = thr_q[ws_w];
		`VPS_F_TIM: rmux = tim_q[ws_w];
		`VPS_F_RST: rmux = rst_q[ws_w];
		`VPS_F_K: rmux = k_q[ws_w];
		default: rmux = 16'h0;
		endcase
	end else begin
		case (addr_i)
		`VPS_A_OPER: rmux = {8'h0, op_q};
		`VPS_A_PICK: rmux = {8'h0, pk_q};
		`VPS_A_GLOB: rmux = {13'h0, alarm_o, prot_trip_o, brk_q};
		default: rmux = 16'h0;
		endcase
	end
end

always @(posedge clk_i or negedge resetn_i) begin
	if (!resetn_i)
		rdata_o <= 16'h0;
	else if (rd_i)
		rdata_o <= rmux;
	else
		rdata_o <= 16'h0;
end

endmodule
`default_nettype wire

//--- common/vps_defs.vh
// Constants for the voltage protection stage logic
`ifndef VPS_DEFS_VH
`define VPS_DEFS_VH
// Time base: 8 ns clock, 1 ms timer tick
`define VPS_CLK_PERIOD_NS 8
`define VPS_TICK_NS 1000000
// Register word index: stage registers at stage*8+field
`define VPS_F_CFG 3'h0
`define VPS_F_THR 3'h1
`define VPS_F_TIM 3'h2
`define VPS_F_RST 3'h3
`define VPS_F_K 3'h4
`define VPS_A_OPER 7'h40
`define VPS_A_PICK 7'h41
`define VPS_A_GLOB 7'h42
// Stage config bit positions
`define VPS_C_EN 0
`define VPS_C_ALM 1
`define VPS_C_AND 2
`define VPS_C_BRK 3
`define VPS_C_CALC 4
`define VPS_C_PP 5
`define VPS_C_INV 6
`define VPS_C_RINV 7
`define VPS_C_CRV_LO 8
`define VPS_C_CRV_HI 11
// Reset delay type encoding
`define VPS_RST_INV 1'b1
`define VPS_RST_DEF 1'b0
// Reset values
`define VPS_CFG_RST 16'h0000
`define VPS_THR_RST 16'h1000
`define VPS_TIM_RST 16'h0064
`define VPS_RST_RST 16'h0000
`define VPS_K_RST 16'h0064
// Coefficient k in hundredths: 0.30 to 1.00
`define VPS_K_MIN 16'h001e
`define VPS_K_MAX 16'h0064
// Stage classes: 0-2 under, 3-5 residual, 6-7 negative sequence
`define VPS_UNDER_MASK 8'h07
`define VPS_RES_MASK 8'h38
`define VPS_INV_MASK 8'h4b
`define VPS_HOLD_MASK 8'h49
// Ratio fixed point (one is 4096), drop-off percentage
`define VPS_ONE_Q12 32'h00001000
`define VPS_DROP_PCT 32'h0000005f
`define VPS_HUNDRED 32'h00000064
// Curve code of the logarithmic curve
`define VPS_CRV_LOG 4'hd
// Logarithmic curve: 5800 ms, 1350 ms, ln2 in Q16
`define VPS_LOG_A_MS 64'sh16a8
`define VPS_LOG_B_MS 64'sh0546
`define VPS_LN2_Q16 64'shb172
// Reset constant tr in ms, and exponent P
`define VPS_TR_IEC_SI 17'h02f44
`define VPS_TR_IEC_VI 17'h0a8c0
`define VPS_TR_IEC_EI 17'h13880
`define VPS_TR_IEEE_MI 17'h01324
`define VPS_TR_IEEE_VI 17'h05460
`define VPS_TR_IEEE_EI 17'h071ac
`define VPS_TR_US_CO8 17'h0173e
`define VPS_TR_US_STI 17'h008d5
`define VPS_TR_ZERO 17'h00000
`define VPS_P_STD 2'h2
`define VPS_P_LOG 2'h0
`endif

//--- verification/vps_stage_logic_props.sv
// Port-level checker for the voltage protection stage logic
`timescale 1ns/1ps
`default_nettype none
module vps_checker (
	input wire logic clk_i, // System clock
	input wire logic resetn_i, // Async reset, active low
	input wire logic [6:0] addr_i, // Register word index
	input wire logic [15:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	input wire logic [15:0] rdata_o, // Read data
	input wire logic prot_trip_o, // Trip level
	input wire logic trip_pulse_o, // Trip pulse
	input wire logic alarm_o // Alarm level
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	////////////////////////////////////////////////////////////////////
	// Trip pulse marks exactly the rising cycle of the trip level
	pulse_rise_a: assert property (trip_pulse_o |->
		prot_trip_o && !$past(prot_trip_o))
		else $error("pulse without trip rise");
	rise_pulse_a: assert property ($rose(prot_trip_o) |->
		trip_pulse_o)
		else $error("trip rise without pulse");
	pulse_width_a: assert property (trip_pulse_o |=>
		!trip_pulse_o)
		else $error("pulse longer than one cycle");
	// Read data only in the cycle after a read strobe
	rd_idle_a: assert property (!rd_i |=>
		rdata_o == 16'h0000)
		else $error("read data without strobe");
	unmap_rd_a: assert property (rd_i && addr_i > 7'h42 |=>
		rdata_o == 16'h0000)
		else $error("unmapped read not zero");
	// Coefficient write clamps into 0.30..1.00
	k_low_a: assert property (
		(wr_i && addr_i == 7'h04 && wdata_i < 16'h001e) ##1
		(rd_i && addr_i == 7'h04) |=> rdata_o == 16'h001e)
		else $error("k not clamped up");
	k_high_a: assert property (
		(wr_i && addr_i == 7'h04 && wdata_i > 16'h0064) ##1
		(rd_i && addr_i == 7'h04) |=> rdata_o == 16'h0064)
		else $error("k not clamped down");
	// Threshold of a stage reads back as written
	thr_back_a: assert property (
		(wr_i && addr_i == 7'h01) ##1 (rd_i && addr_i == 7'h01) |=>
		rdata_o == $past(wdata_i, 2))
		else $error("threshold readback");
	// Main scenarios reached
	trip_c: cover property ($rose(prot_trip_o));
	alarm_c: cover property ($rose(alarm_o));
	kclamp_c: cover property (wr_i && addr_i == 7'h04 && wdata_i < 16'h001e);
endmodule
bind vps_stage_logic vps_checker u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .prot_trip_o(prot_trip_o),
	.trip_pulse_o(trip_pulse_o), .alarm_o(alarm_o));
`default_nettype wire

//--- verification/vps_front_model.sv
// Model of the voltage front end and breaker auxiliary contact
`timescale 1ns/1ps
`default_nettype none
module vps_front_model #(
	parameter logic [15:0] NOM = 16'h00c8 // Healthy phase level
) (
	input wire logic clk_i, // System clock
	input wire logic [2:0] sag_i, // Phases pulled down
	input wire logic [15:0] sag_lvl_i, // Level of a sagged phase
	input wire logic [15:0] nseq_lvl_i, // Negative-sequence level
	input wire logic brk_i, // Breaker commanded closed
	output logic [15:0] van_o, // Phase A to neutral
	output logic [15:0] vbn_o, // Phase B to neutral
	output logic [15:0] vcn_o, // Phase C to neutral
	output logic [15:0] vab_o, // Phase A to B
	output logic [15:0] vbc_o, // Phase B to C
	output logic [15:0] vca_o, // Phase C to A
	output logic [15:0] res_o, // Measured residual
	output logic [15:0] nseq_o, // Negative sequence
	output logic brk_o // Breaker closed contact
);
	////////////////////////////////////////////////////////////////////
	// Measurements refresh on the clock like a real sampler
	always @(posedge clk_i) begin
		van_o <= sag_i[0] ? sag_lvl_i : NOM;
		vbn_o <= sag_i[1] ? sag_lvl_i : NOM;
		vcn_o <= sag_i[2] ? sag_lvl_i : NOM;
		vab_o <= |sag_i[1:0] ? sag_lvl_i : NOM;
		vbc_o <= |sag_i[2:1] ? sag_lvl_i : NOM;
		vca_o <= sag_i[2] | sag_i[0] ? sag_lvl_i : NOM;
		res_o <= 16'h0000;
		nseq_o <= nseq_lvl_i;
	end
	// Contact settles three cycles late, as auxiliary contacts lag
	logic [1:0] lag_q;
	always @(posedge clk_i) begin
		lag_q <= {lag_q[0], brk_i};
		brk_o <= lag_q[1];
	end
endmodule
`default_nettype wire

//--- verification/vps_stage_logic_tb.sv
// Self-checking bench for the voltage protection stage logic
`timescale 1ns/1ps
`default_nettype none
module vps_stage_logic_tb;
	logic clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, brk = 0;
	logic [6:0] addr_i = 0;
	logic [15:0] wdata_i = 0, sag_lvl = 16'h0032, nseq_lvl = 0;
	logic [2:0] sag = 0;
	logic [15:0] rdata_o, van, vbn, vcn, vab, vbc, vca, res, nseq;
	logic brk_c, prot_trip_o, trip_pulse_o, alarm_o;
	int n_mismatch = 0, checked = 0, cyc = 0, n_pulse = 0;
	always #4 clk_i = ~clk_i;
	// Count trip pulses on the falling edge, away from their launch
	always @(negedge clk_i)
		if (trip_pulse_o === 1'b1)
			n_pulse++;
	vps_front_model u_fe (.clk_i(clk_i), .sag_i(sag), .sag_lvl_i(sag_lvl),
		.nseq_lvl_i(nseq_lvl), .brk_i(brk), .van_o(van), .vbn_o(vbn),
		.vcn_o(vcn), .vab_o(vab), .vbc_o(vbc), .vca_o(vca), .res_o(res),
		.nseq_o(nseq), .brk_o(brk_c));
	vps_stage_logic #(.TICK_CYC(10)) u_dut (.clk_i(clk_i),
		.resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .van_i(van),
		.vbn_i(vbn), .vcn_i(vcn), .vab_i(vab), .vbc_i(vbc), .vca_i(vca),
		.res_i(res), .nseq_i(nseq), .breaker_closed_contact_i(brk_c),
		.prot_trip_o(prot_trip_o), .trip_pulse_o(trip_pulse_o),
		.alarm_o(alarm_o));
	////////////////////////////////////////////////////////////////////
	// Compare, bus and wait helpers
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic r, input logic [6:0] a,
		input logic [15:0] d);
		@(posedge clk_i);
		wr_i <= w;
		rd_i <= r;
		addr_i <= a;
		wdata_i <= d;
	endtask
	task wr(input logic [6:0] a, input logic [15:0] d);
		bus(1, 0, a, d);
		bus(0, 0, 0, 0);
	endtask
	// Read data stand only in the cycle after the strobe
	task rd(input logic [6:0] a, output logic [15:0] d);
		bus(0, 1, a, 0);
		bus(0, 0, 0, 0);
		#1 d = rdata_o;
	endtask
	// Wait n cycles, noting any trip (sel 0) or alarm (sel 1)
	task wait_out(input int n, input bit sel, output logic seen);
		seen = 0;
		repeat (n) begin
			@(posedge clk_i);
			#1 if ((sel ? alarm_o : prot_trip_o) === 1'b1) seen = 1;
		end
	endtask
	////////////////////////////////////////////////////////////////////
	// Reset values, k clamping, unmapped read
	task t_regs;
		logic [15:0] d;
		rd(7'h00, d);
		chk(d, 16'h0000);
		rd(7'h01, d);
		chk(d, 16'h1000);
		rd(7'h02, d);
		chk(d, 16'h0064);
		rd(7'h04, d);
		chk(d, 16'h0064);
		bus(1, 0, 7'h04, 16'h0005);
		rd(7'h04, d);
		chk(d, 16'h001e);
		bus(1, 0, 7'h04, 16'h00c8);
		rd(7'h04, d);
		chk(d, 16'h0064);
		bus(1, 0, 7'h01, 16'h0064);
		rd(7'h01, d);
		chk(d, 16'h0064);
		rd(7'h7f, d);
		chk(d, 16'h0000);
		$display("test regs done");
	endtask
	// Undervoltage OR trip on one phase, zero hold clears at once
	task t_uv_or;
		logic s;
		int p0;
		wr(7'h02, 16'h0000);
		wr(7'h00, 16'h0001);
		p0 = n_pulse;
		sag <= 3'b010;
		wait_out(20, 0, s);
		chk(s, 1);
		chk(n_pulse - p0, 1);
		chk(alarm_o, 0);
		sag <= 3'b000;
		repeat (20) @(posedge clk_i);
		#1 chk(prot_trip_o, 0);
		wr(7'h00, 16'h0000);
		$display("test uv_or done");
	endtask
	// AND mode needs every phase low
	task t_uv_and;
		logic s;
		wr(7'h09, 16'h0064);
		wr(7'h0a, 16'h0000);
		wr(7'h08, 16'h0005);
		sag <= 3'b011;
		wait_out(40, 0, s);
		chk(s, 0);
		sag <= 3'b111;
		wait_out(20, 0, s);
		chk(s, 1);
		sag <= 3'b000;
		wr(7'h08, 16'h0000);
		$display("test uv_and done");
	endtask
	// Breaker-qualified negative-sequence alarm
	task t_nseq;
		logic s;
		wr(7'h31, 16'h0064);
		wr(7'h32, 16'h0000);
		wr(7'h30, 16'h000b);
		nseq_lvl <= 16'h00c8;
		wait_out(40, 1, s);
		chk(s, 0);
		brk <= 1;
		wait_out(25, 1, s);
		chk(s, 1);
		chk(prot_trip_o, 0);
		nseq_lvl <= 16'h0000;
		brk <= 0;
		wr(7'h30, 16'h0000);
		$display("test nseq done");
	endtask
	// Intermittent fault adds up only with a nonzero hold
	task t_hold;
		logic s;
		logic [15:0] hold[2];
		logic exp[2];
		hold = '{16'h001e, 16'h0000};
		exp = '{1'b1, 1'b0};
		wr(7'h02, 16'h0014);
		for (int i = 0; i < 2; i++) begin
			wr(7'h03, hold[i]);
			wr(7'h00, 16'h0001);
			sag <= 3'b001;
			repeat (100) @(posedge clk_i);
			sag <= 3'b000;
			repeat (100) @(posedge clk_i);
			sag <= 3'b001;
			wait_out(150, 0, s);
			chk(s, exp[i]);
			sag <= 3'b000;
			wr(7'h00, 16'h0000);
			repeat (400) @(posedge clk_i);
			#1 chk(prot_trip_o, 0);
		end
		$display("test hold done");
	endtask
	// Residual stage: measured input is zero, summed phases are not
	task t_resid;
		logic s;
		wr(7'h19, 16'h0200);
		wr(7'h1a, 16'h0000);
		wr(7'h18, 16'h0001);
		wait_out(40, 0, s);
		chk(s, 0);
		wr(7'h18, 16'h0011);
		wait_out(20, 0, s);
		chk(s, 1);
		wr(7'h18, 16'h0000);
		$display("test resid done");
	endtask
	////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task stop_test;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test;
		end
	end
	initial begin
		repeat (4) @(posedge clk_i);
		resetn_i <= 1;
		t_regs;
		t_uv_or;
		t_uv_and;
		t_nseq;
		t_resid;
		t_hold;
		stop_test;
	end
endmodule
`default_nettype wire
